/* hdl/hmrc_top.sv */
// Our own choice: the address-and-strobe port.
`timescale 1ns/100ps
module hmrc_top
    import hmrc_pkg::*;
#(
    parameter logic [15:0] FE_ERR_CODE = 16'h0001 // Logged code for following error, arbitrary
) (
    input wire logic CLOCK_IN,
    input wire logic RST_IN,
    input wire logic [15:0] ADDR_IN,
    input wire logic [31:0] WDATA_IN,
    input wire logic WR_IN,
    input wire logic RD_IN,
    input wire logic LIMIT_SW_IN,
    input wire logic ERROR_IN,
    input wire logic [15:0] ERROR_CODE_IN,
    input wire logic FOLLOW_ERR_IN,
    input wire logic RAMP_DONE_IN,
    output logic [31:0] RDATA_OUT,
    output logic [1:0] BRAKE_MODE_OUT,
    output logic POWER_EN_OUT,
    output logic [2:0] STATE_OUT,
    output logic IRQ_OUT
);
    // ************************************************************
    // Storage
    // ************************************************************
    hmrc_state_t state; // Power state
    hmrc_state_t target; // State to enter once braking ends
    logic [15:0] cw; // Command word
    logic [15:0] cw_prev; // Command word of the previous cycle
    logic [7:0] mode_req; // Requested mode
    logic [7:0] mode_disp; // Mode in effect
    logic [15:0] qs_code, sd_code, do_code, halt_code, flt_code, fe_code; // Reaction codes
    logic [31:0] fe_win; // Following error window
    logic [31:0] max_slip; // Maximum slippage
    logic [15:0] err_hist; // Latest error code
    logic [EV_W-1:0] irq_sts; // Sticky events
    logic [EV_W-1:0] irq_mask; // Enabled events
    logic lim_s1, lim_s2, lim_d; // Limit switch synchroniser and edge
    hmrc_state_t next_state, next_target;
    logic [1:0] next_brake;
    logic next_pwr;

    // ************************************************************
    // Decoding
    // ************************************************************
    // Write strobes per register
    wire wr_cw = WR_IN && ADDR_IN == OFS_CMD_WORD;
    wire wr_mode = WR_IN && ADDR_IN == OFS_MODE_REQ;
    wire wr_qs = WR_IN && ADDR_IN == OFS_QS_REACT;
    wire wr_sd = WR_IN && ADDR_IN == OFS_SD_REACT;
    wire wr_do = WR_IN && ADDR_IN == OFS_DO_REACT;
    wire wr_halt = WR_IN && ADDR_IN == OFS_HALT_REACT;
    wire wr_flt = WR_IN && ADDR_IN == OFS_FLT_REACT;
    wire wr_fe = WR_IN && ADDR_IN == OFS_FE_REACT;
    wire [15:0] wcode = WDATA_IN[15:0];
    // Accepted code sets; anything else keeps the stored code
    wire ok_qs = wcode inside {16'h0000, 16'h0001, 16'h0002, 16'h0005, 16'h0006};
    wire ok_sd = wcode inside {16'h0000, 16'h0001};
    wire ok_halt = wcode inside {16'h0001, 16'h0002};
    wire ok_flt = wcode inside {16'h0000, 16'h0001, 16'h0002};
    wire ok_fe = ok_flt || wcode == CODE_NO_REACT;
    // Command word decode
    wire c_shutdown = !cw[CW_FRST] && cw[CW_QS_N] && cw[CW_VOLT] && !cw[CW_ON];
    wire c_switch_on = !cw[CW_FRST] && !cw[CW_ENOP] && cw[CW_QS_N] && cw[CW_VOLT] && cw[CW_ON];
    wire c_enable = !cw[CW_FRST] && cw[CW_ENOP] && cw[CW_QS_N] && cw[CW_VOLT] && cw[CW_ON];
    wire c_dis_volt = !cw[CW_FRST] && !cw[CW_VOLT];
    wire c_qstop = !cw[CW_FRST] && !cw[CW_QS_N] && cw[CW_VOLT];
    // Return from quick stop and fault reset act on an edge only
    wire enable_was = cw_prev[CW_ENOP] && cw_prev[CW_QS_N] && cw_prev[CW_VOLT] && cw_prev[CW_ON];
    wire enable_rise = c_enable && !(enable_was && !cw_prev[CW_FRST]);
    wire frst_rise = cw[CW_FRST] && !cw_prev[CW_FRST];
    wire lim_rise = lim_s2 && !lim_d;
    // Monitoring is off for either sentinel value
    wire fe_mon_en = fe_win != FE_WIN_OFF && max_slip != SLIP_OFF;
    wire fe_ev = FOLLOW_ERR_IN && fe_mon_en && fe_code != CODE_NO_REACT;
    wire err_ev = ERROR_IN || fe_ev;
    wire [15:0] err_code = ERROR_IN ? flt_code : fe_code;
    wire powered = state inside {ST_SWON, ST_OPEN, ST_QSA, ST_STOP};
    wire in_fault = state inside {ST_FREACT, ST_FAULT};
    wire halt_mode = mode_disp inside {MODE_PP, MODE_VL, MODE_PV, MODE_TQ, MODE_IP};
    wire halt_act = cw[CW_HALT] && halt_mode;
    wire stop_done = RAMP_DONE_IN && (state == ST_STOP || (state == ST_QSA && BRAKE_MODE_OUT != BRK_NONE));
    wire [EV_W-1:0] ev = {stop_done, lim_rise, fe_ev, err_ev && !in_fault};
    wire rd_sts = RD_IN && ADDR_IN == OFS_IRQ_STS;
    wire [EV_W-1:0] next_sts = ev | (rd_sts ? '0 : irq_sts);
    // Read multiplexer, unmapped reads return zero
    wire [31:0] rd_mux =
        ADDR_IN == OFS_ERR_HIST ? {16'h0000, err_hist} :
        ADDR_IN == OFS_IRQ_STS ? {28'h0, irq_sts} :
        ADDR_IN == OFS_IRQ_MASK ? {28'h0, irq_mask} :
        ADDR_IN == OFS_FE_REACT ? {16'h0000, fe_code} :
        ADDR_IN == OFS_CMD_WORD ? {16'h0000, cw} :
        ADDR_IN == OFS_PWR_STS ? {29'h0, STATE_OUT} :
        ADDR_IN == OFS_QS_REACT ? {16'h0000, qs_code} :
        ADDR_IN == OFS_SD_REACT ? {16'h0000, sd_code} :
        ADDR_IN == OFS_DO_REACT ? {16'h0000, do_code} :
        ADDR_IN == OFS_HALT_REACT ? {16'h0000, halt_code} :
        ADDR_IN == OFS_FLT_REACT ? {16'h0000, flt_code} :
        ADDR_IN == OFS_MODE_REQ ? {24'h0, mode_req} :
        ADDR_IN == OFS_MODE_DISP ? {24'h0, mode_disp} :
        ADDR_IN == OFS_FE_WIN ? fe_win :
        ADDR_IN == OFS_MAX_SLIP ? max_slip : 32'h0;

    // ************************************************************
    // Power state and reaction selection
    // ************************************************************
    // Errors outrank every command outside ST_FREACT and ST_FAULT; braking ends on the ramp's done flag, halt braking once halt_act drops
    always_comb begin
        next_state = state;
        next_target = target;
        next_brake = BRAKE_MODE_OUT;
        next_pwr = POWER_EN_OUT;
        if (err_ev && !in_fault) begin
            // Fault code 0, or nothing to brake, drops power at once
            if (err_code == 16'h0000 || !powered) begin
                next_state = ST_FAULT;
                next_brake = BRK_NONE;
                next_pwr = 1'b0;
            end else begin
                next_state = ST_FREACT;
                next_brake = err_code[1:0];
            end
        end else begin
            unique case (state)
                ST_SOD: begin
                    if (c_shutdown) begin
                        next_state = ST_RTSO;
                    end
                end
                ST_RTSO: begin
                    if (c_dis_volt || c_qstop) begin
                        next_state = ST_SOD;
                    end else if (c_switch_on || c_enable) begin
                        next_state = ST_SWON;
                        next_pwr = 1'b1;
                    end
                end
                ST_SWON: begin
                    if (c_dis_volt || c_qstop) begin
                        next_state = ST_SOD;
                        next_pwr = 1'b0;
                    end else if (c_shutdown) begin
                        next_state = ST_RTSO;
                        next_pwr = 1'b0;
                    end else if (c_enable) begin
                        next_state = ST_OPEN;
                    end
                end
                ST_OPEN: begin
                    if (c_qstop || lim_rise) begin
                        // Immediate stop releases the motor
                        if (qs_code == 16'h0000) begin
                            next_state = ST_SOD;
                            next_brake = BRK_NONE;
                            next_pwr = 1'b0;
                        end else if (qs_code == 16'h0005 || qs_code == 16'h0006) begin
                            next_state = ST_QSA;
                            next_brake = qs_code == 16'h0005 ? BRK_SLOW : BRK_QUICK;
                        end else begin
                            next_state = ST_STOP;
                            next_target = ST_SOD;
                            next_brake = qs_code[1:0];
                        end
                    end else if (c_dis_volt) begin
                        next_state = ST_SOD;
                        next_brake = BRK_NONE;
                        next_pwr = 1'b0;
                    end else if (c_shutdown) begin
                        if (sd_code == 16'h0000) begin
                            next_state = ST_RTSO;
                            next_brake = BRK_NONE;
                            next_pwr = 1'b0;
                        end else begin
                            next_state = ST_STOP;
                            next_target = ST_RTSO;
                            next_brake = BRK_SLOW;
                        end
                    end else if (c_switch_on) begin
                        // Code 0 frees the motor but the stage stays switched on
                        next_state = do_code == 16'h0000 ? ST_SWON : ST_STOP;
                        next_target = ST_SWON;
                        next_brake = do_code == 16'h0000 ? BRK_NONE : BRK_SLOW;
                    end else begin
                        next_brake = halt_act ? halt_code[1:0] : BRK_NONE;
                    end
                end
                ST_QSA: begin
                    // Motor stays energized until commanded otherwise
                    if (c_dis_volt) begin
                        next_state = ST_SOD;
                        next_brake = BRK_NONE;
                        next_pwr = 1'b0;
                    end else if (enable_rise) begin
                        next_state = ST_OPEN;
                        next_brake = BRK_NONE;
                    end else if (RAMP_DONE_IN) begin
                        next_brake = BRK_NONE;
                    end
                end
                ST_STOP: begin
                    if (RAMP_DONE_IN) begin
                        next_state = target;
                        next_brake = BRK_NONE;
                        next_pwr = target == ST_SWON;
                    end
                end
                ST_FREACT: begin
                    if (RAMP_DONE_IN) begin
                        next_state = ST_FAULT;
                        next_brake = BRK_NONE;
                        next_pwr = 1'b0;
                    end
                end
                ST_FAULT: begin
                    if (frst_rise) begin
                        next_state = ST_SOD;
                    end
                end
            endcase
        end
    end

    // State and drive outputs
    always_ff @(posedge CLOCK_IN) begin
        if (RST_IN) begin
            state <= ST_SOD;
            target <= ST_SOD;
            BRAKE_MODE_OUT <= BRK_NONE;
            POWER_EN_OUT <= 1'b0;
            STATE_OUT <= 3'h0;
        end else begin
            state <= next_state;
            target <= next_target;
            BRAKE_MODE_OUT <= next_brake;
            POWER_EN_OUT <= next_pwr;
            STATE_OUT <= 3'(next_state);
        end
    end

    // ************************************************************
    // Input conditioning
    // ************************************************************
    // Limit switch is an asynchronous pin: two flops before use
    always_ff @(posedge CLOCK_IN) begin
        if (RST_IN) begin
            lim_s1 <= 1'b0;
            lim_s2 <= 1'b0;
            lim_d <= 1'b0;
        end else begin
            lim_s1 <= LIMIT_SW_IN;
            lim_s2 <= lim_s1;
            lim_d <= lim_s2;
        end
    end

    // ************************************************************
    // Register file
    // ************************************************************
    // Command word and mode request accept writes in any state
    always_ff @(posedge CLOCK_IN) begin
        if (RST_IN) begin
            cw <= 16'h0000;
            cw_prev <= 16'h0000;
            mode_req <= 8'h00;
            mode_disp <= 8'h00;
        end else begin
            cw_prev <= cw;
            if (wr_cw) begin
                cw <= wcode;
            end
            if (wr_mode) begin
                mode_req <= WDATA_IN[7:0];
            end
            // A new mode takes effect only outside the ST_STOP and ST_FREACT states
            if (state != ST_STOP && state != ST_FREACT) begin
                mode_disp <= mode_req;
            end
        end
    end

    // Reaction codes; reserved values leave the old code in place
    always_ff @(posedge CLOCK_IN) begin
        if (RST_IN) begin
            qs_code <= RST_QS_REACT;
            sd_code <= RST_SD_REACT;
            do_code <= RST_DO_REACT;
            halt_code <= RST_HALT_REACT;
            flt_code <= RST_FLT_REACT;
            fe_code <= RST_FE_REACT;
        end else begin
            if (wr_qs && ok_qs) qs_code <= wcode;
            if (wr_sd && ok_sd) sd_code <= wcode;
            if (wr_do && ok_sd) do_code <= wcode;
            if (wr_halt && ok_halt) halt_code <= wcode;
            if (wr_flt && ok_flt) flt_code <= wcode;
            if (wr_fe && ok_fe) fe_code <= wcode;
        end
    end

    // Monitor limits, error log, interrupts and read data
    always_ff @(posedge CLOCK_IN) begin
        if (RST_IN) begin
            fe_win <= RST_FE_WIN;
            max_slip <= RST_MAX_SLIP;
            err_hist <= 16'h0000;
            irq_sts <= '0;
            irq_mask <= '0;
            IRQ_OUT <= 1'b0;
            RDATA_OUT <= 32'h0;
        end else begin
            if (WR_IN && ADDR_IN == OFS_FE_WIN) fe_win <= WDATA_IN;
            if (WR_IN && ADDR_IN == OFS_MAX_SLIP) max_slip <= WDATA_IN;
            if (WR_IN && ADDR_IN == OFS_IRQ_MASK) irq_mask <= WDATA_IN[EV_W-1:0];
            // Device error wins when both arrive together
            if (ERROR_IN) begin
                err_hist <= ERROR_CODE_IN;
            end else if (fe_ev) begin
                err_hist <= FE_ERR_CODE;
            end
            // New events win over the read that clears
            irq_sts <= next_sts;
            IRQ_OUT <= |(next_sts & irq_mask);
            RDATA_OUT <= RD_IN ? rd_mux : 32'h0;
        end
    end

    // ************************************************************
    // Assertions
    // ************************************************************
    default clocking cb @(posedge CLOCK_IN); endclocking
    default disable iff (RST_IN);

    wire open_quiet = state == ST_OPEN && !err_ev;
    wire qs_trig = open_quiet && (c_qstop || lim_rise);

    property p_mode_req;
        wr_mode |=> mode_req == $past(WDATA_IN[7:0]);
    endproperty
    a_mode_req: assert property (p_mode_req) else $error("mode request lost");

    property p_qs_ramp;
        qs_trig && qs_code == 16'h0002 |=> state == ST_STOP && BRAKE_MODE_OUT == BRK_QUICK && target == ST_SOD;
    endproperty
    a_qs_ramp: assert property (p_qs_ramp) else $error("quick stop code 2 wrong");

    property p_qs_hold;
        qs_trig && qs_code == 16'h0005 |=> state == ST_QSA && BRAKE_MODE_OUT == BRK_SLOW && POWER_EN_OUT;
    endproperty
    a_qs_hold: assert property (p_qs_hold) else $error("quick stop code 5 wrong");

    property p_limit;
        open_quiet && lim_rise |=> state inside {ST_STOP, ST_QSA, ST_SOD};
    endproperty
    a_limit: assert property (p_limit) else $error("limit switch ignored");

    property p_shutdown;
        open_quiet && c_shutdown && !c_qstop && !lim_rise && sd_code == 16'h0000
            |=> state == ST_RTSO && !POWER_EN_OUT;
    endproperty
    a_shutdown: assert property (p_shutdown) else $error("shutdown code 0 wrong");

    property p_disop;
        open_quiet && c_switch_on && !lim_rise && do_code == 16'h0001 |=> state == ST_STOP ##1 target == ST_SWON;
    endproperty
    a_disop: assert property (p_disop) else $error("disable operation ramp wrong");

    property p_halt;
        open_quiet && !lim_rise && cw[CW_HALT] && cw[CW_QS_N] && c_enable && halt_mode
            |=> BRAKE_MODE_OUT == $past(halt_code[1:0]);
    endproperty
    a_halt: assert property (p_halt) else $error("halt not applied");

    property p_halt_mode;
        open_quiet && !lim_rise && c_enable && !halt_mode |=> BRAKE_MODE_OUT == BRK_NONE;
    endproperty
    a_halt_mode: assert property (p_halt_mode) else $error("halt in wrong mode");

    property p_fault;
        ERROR_IN && powered && !in_fault && flt_code == 16'h0002
            |=> state == ST_FREACT && BRAKE_MODE_OUT == BRK_QUICK;
    endproperty
    a_fault: assert property (p_fault) else $error("fault reaction wrong");

    property p_hist;
        ERROR_IN |=> err_hist == $past(ERROR_CODE_IN);
    endproperty
    a_hist: assert property (p_hist) else $error("error code not logged");

    property p_follow;
        fe_ev && !ERROR_IN && !in_fault && fe_code == 16'h0000 |=> state == ST_FAULT && !POWER_EN_OUT;
    endproperty
    a_follow: assert property (p_follow) else $error("following error reaction wrong");

    property p_mon_off;
        fe_win == FE_WIN_OFF && FOLLOW_ERR_IN && !ERROR_IN && !in_fault |=> err_hist == $past(err_hist) && !in_fault;
    endproperty
    a_mon_off: assert property (p_mon_off) else $error("monitor not disabled");

    property p_reject;
        wr_halt && !ok_halt |=> halt_code == $past(halt_code);
    endproperty
    a_reject: assert property (p_reject) else $error("reserved code stored");

    c_qs_hold: cover property (qs_trig && qs_code == 16'h0006 ##1 state == ST_QSA);
    c_stop_done: cover property (state == ST_STOP ##1 state == ST_RTSO);
    c_fault_rst: cover property (state == ST_FAULT ##1 state == ST_SOD);
    c_halt: cover property (state == ST_OPEN && halt_act);
endmodule

/* shared/hmrc_pkg.sv */
// ************************************************************
// Halt motion reaction control: shared constants
// ************************************************************
package hmrc_pkg;
    // Register offsets, word addressed
    localparam logic [15:0] OFS_ERR_HIST = 16'h1003;   // Latest error code
    localparam logic [15:0] OFS_IRQ_STS = 16'h2000;    // Sticky events, read clears
    localparam logic [15:0] OFS_IRQ_MASK = 16'h2001;   // Interrupt mask
    localparam logic [15:0] OFS_FE_REACT = 16'h3700;   // Following error reaction
    localparam logic [15:0] OFS_CMD_WORD = 16'h6040;   // Command word
    localparam logic [15:0] OFS_PWR_STS = 16'h6041;    // Power state read-back
    localparam logic [15:0] OFS_QS_REACT = 16'h605A;   // Quick stop reaction
    localparam logic [15:0] OFS_SD_REACT = 16'h605B;   // Shutdown reaction
    localparam logic [15:0] OFS_DO_REACT = 16'h605C;   // Disable operation reaction
    localparam logic [15:0] OFS_HALT_REACT = 16'h605D; // Halt reaction
    localparam logic [15:0] OFS_FLT_REACT = 16'h605E;  // Fault reaction
    localparam logic [15:0] OFS_MODE_REQ = 16'h6060;   // Requested mode
    localparam logic [15:0] OFS_MODE_DISP = 16'h6061;  // Mode in effect
    localparam logic [15:0] OFS_FE_WIN = 16'h6065;     // Following error window
    localparam logic [15:0] OFS_MAX_SLIP = 16'h60F8;   // Maximum slippage
    // Reset values of the reaction codes and monitor limits
    localparam logic [15:0] RST_QS_REACT = 16'h0002;
    localparam logic [15:0] RST_SD_REACT = 16'h0001;
    localparam logic [15:0] RST_DO_REACT = 16'h0001;
    localparam logic [15:0] RST_HALT_REACT = 16'h0001;
    localparam logic [15:0] RST_FLT_REACT = 16'h0002;
    localparam logic [15:0] RST_FE_REACT = 16'h0002;
    localparam logic [31:0] RST_FE_WIN = 32'h0000_1000;
    localparam logic [31:0] RST_MAX_SLIP = 32'h0000_1000;
    // Special values
    localparam logic [15:0] CODE_NO_REACT = 16'hFFFF;   // Following error: ignore
    localparam logic [31:0] FE_WIN_OFF = 32'hFFFF_FFFF; // Window value that disables monitor
    localparam logic [31:0] SLIP_OFF = 32'h7FFF_FFFF;   // Slippage value that disables monitor
    // Command word bit positions
    localparam int CW_ON = 0;
    localparam int CW_VOLT = 1;
    localparam int CW_QS_N = 2;
    localparam int CW_ENOP = 3;
    localparam int CW_FRST = 7;
    localparam int CW_HALT = 8;
    // Operating modes for which halt is honoured
    localparam logic [7:0] MODE_PP = 8'h01;
    localparam logic [7:0] MODE_VL = 8'h02;
    localparam logic [7:0] MODE_PV = 8'h03;
    localparam logic [7:0] MODE_TQ = 8'h04;
    localparam logic [7:0] MODE_IP = 8'h07;
    // Brake command to the ramp generator
    localparam logic [1:0] BRK_NONE = 2'h0;
    localparam logic [1:0] BRK_SLOW = 2'h1;
    localparam logic [1:0] BRK_QUICK = 2'h2;
    // Interrupt status bits
    localparam int EV_FAULT = 0;
    localparam int EV_FOLLOW = 1;
    localparam int EV_LIMIT = 2;
    localparam int EV_STOPPED = 3;
    localparam int EV_W = 4;
    // Power states
    typedef enum logic [2:0] {ST_SOD, ST_RTSO, ST_SWON, ST_OPEN, ST_QSA, ST_STOP, ST_FREACT, ST_FAULT} hmrc_state_t;
endpackage

/* sim/hmrc_master.sv */
`timescale 1ns/100ps
// ************************************************
// Fieldbus master model: one-cycle strobes
// ************************************************
module hmrc_master (
    input wire logic CLOCK_IN,
    input wire logic [31:0] RDATA_IN,
    output logic [15:0] ADDR_OUT = 16'h0000,
    output logic [31:0] WDATA_OUT = 32'h0000_0000,
    output logic WR_OUT = 1'b0,
    output logic RD_OUT = 1'b0
);
    // Commands and option codes reach the drive only by register writes
    task automatic wr(input logic [15:0] a, input logic [31:0] d);
        @(posedge CLOCK_IN);
        ADDR_OUT <= a;
        WDATA_OUT <= d;
        WR_OUT <= 1'b1;
        @(posedge CLOCK_IN);
        WR_OUT <= 1'b0;
    endtask
    // Read data stand only in the cycle after the strobe
    task automatic rd(input logic [15:0] a, output logic [31:0] d);
        @(posedge CLOCK_IN);
        ADDR_OUT <= a;
        RD_OUT <= 1'b1;
        @(posedge CLOCK_IN);
        RD_OUT <= 1'b0;
        #1 d = RDATA_IN;
    endtask
endmodule

/* sim/halt_motion_reaction_control_tb.sv */
`timescale 1ns/100ps
module halt_motion_reaction_control_tb;
    import hmrc_pkg::*;
    logic clk, rst, wr, rd, lim, err, ferr, rdone, pwr, irq;
    logic [15:0] addr, ecode;
    logic [31:0] wdata, rdata, v;
    logic [1:0] brake;
    logic [2:0] state;
    int fail_count = 0, n_checks = 0, seed = 22903;
    int mdl[int]; // Expected register contents
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    hmrc_top hmrc_top_inst (.CLOCK_IN(clk), .RST_IN(rst), .ADDR_IN(addr), .WDATA_IN(wdata),
        .WR_IN(wr), .RD_IN(rd), .LIMIT_SW_IN(lim), .ERROR_IN(err), .ERROR_CODE_IN(ecode),
        .FOLLOW_ERR_IN(ferr), .RAMP_DONE_IN(rdone), .RDATA_OUT(rdata), .BRAKE_MODE_OUT(brake),
        .POWER_EN_OUT(pwr), .STATE_OUT(state), .IRQ_OUT(irq));
    hmrc_master hmrc_master_inst (.CLOCK_IN(clk), .RDATA_IN(rdata), .ADDR_OUT(addr),
        .WDATA_OUT(wdata), .WR_OUT(wr), .RD_OUT(rd));
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic finish_test;
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    // Model refuses reserved halt codes and mirrors the mode request
    task automatic wrm(input logic [15:0] a, input logic [31:0] d);
        if (a != OFS_HALT_REACT || d inside {1, 2}) mdl[a] = d;
        if (a == OFS_MODE_REQ) mdl[OFS_MODE_DISP] = d;
        hmrc_master_inst.wr(a, d);
    endtask
    task automatic rdchk(input logic [15:0] a);
        hmrc_master_inst.rd(a, v);
        check(v, mdl[a]);
    endtask
    task automatic wait2;
        repeat (2) @(posedge clk);
        #1;
    endtask
    // Shutdown, switch on, enable: one power state per command
    task automatic power_up;
        for (int i = 0; i < 3; i++) begin
            wrm(OFS_CMD_WORD, i == 0 ? 32'h6 : i == 1 ? 32'h7 : 32'hF);
            wait2();
            check({29'h0, state}, i + 1);
        end
    endtask
    // One-cycle following error event, launched on a rising edge
    task automatic pulse_ferr;
        @(posedge clk);
        ferr <= 1'b1;
        @(posedge clk);
        ferr <= 1'b0;
        wait2();
    endtask
    // Watchdog: a hang counts as a mismatch
    initial begin
        #500000;
        fail_count++;
        finish_test();
    end
    initial begin
        {rst, lim, err, ferr, rdone, ecode} = {1'b1, 4'h0, 16'h0000};
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        mdl = '{OFS_QS_REACT: RST_QS_REACT, OFS_SD_REACT: RST_SD_REACT, OFS_DO_REACT: RST_DO_REACT,
            OFS_HALT_REACT: RST_HALT_REACT, OFS_FLT_REACT: RST_FLT_REACT, OFS_FE_REACT: RST_FE_REACT,
            OFS_FE_WIN: RST_FE_WIN, OFS_MAX_SLIP: RST_MAX_SLIP, OFS_IRQ_MASK: 0, OFS_MODE_DISP: 0, 16'h0123: 0};
        foreach (mdl[a]) rdchk(16'(a));
        for (int c = 0; c < 4; c++) begin
            wrm(OFS_HALT_REACT, c);
            rdchk(OFS_HALT_REACT);
        end
        v = $random(seed);
        wrm(OFS_MODE_REQ, {29'h0, v[2:0]});
        rdchk(OFS_MODE_DISP);
        power_up();
        wrm(OFS_CMD_WORD, 32'h0000_000B);
        wait2();
        check({27'h0, state, brake}, {27'h0, 3'h5, BRK_QUICK});
        rdone <= 1'b1;
        wait2();
        check({28'h0, state, pwr}, 32'h0);
        rdone <= 1'b0;
        hmrc_master_inst.rd(OFS_IRQ_STS, v);
        check(v, 32'h8);
        wrm(OFS_IRQ_MASK, 32'hF);
        v = $random(seed);
        @(posedge clk);
        err <= 1'b1;
        ecode <= v[15:0];
        @(posedge clk);
        err <= 1'b0;
        wait2();
        check({28'h0, state, irq}, {28'h0, 3'h7, 1'b1});
        mdl[OFS_ERR_HIST] = {16'h0, v[15:0]};
        rdchk(OFS_ERR_HIST);
        hmrc_master_inst.rd(OFS_IRQ_STS, v);
        check(v, 32'h1);
        wait2();
        check({31'h0, irq}, 32'h0);
        // Fault reset, then stay-energized quick stop and a halt-capable mode
        wrm(OFS_CMD_WORD, 32'h80);
        wait2();
        check({29'h0, state}, 32'h0);
        wrm(OFS_QS_REACT, 32'h5);
        wrm(OFS_MODE_REQ, 32'h1);
        power_up();
        wrm(OFS_CMD_WORD, 32'h10F);
        wait2();
        check({30'h0, brake}, mdl[OFS_HALT_REACT]);
        // A mode outside the halt list drops the brake request
        wrm(OFS_MODE_REQ, 32'h6);
        wait2();
        check({30'h0, brake}, 32'h0);
        // Limit switch passes two sync flops, then acts on its edge
        @(posedge clk);
        lim <= 1'b1;
        wait2();
        wait2();
        check({26'h0, state, brake, pwr}, {26'h0, 3'h4, BRK_SLOW, 1'b1});
        wrm(OFS_CMD_WORD, 32'hB);
        wrm(OFS_CMD_WORD, 32'hF);
        wait2();
        check({29'h0, state}, 32'h3);
        // All-ones window hides the following error, the reset window does not
        wrm(OFS_FE_WIN, 32'hFFFF_FFFF);
        pulse_ferr();
        check({29'h0, state}, 32'h3);
        wrm(OFS_FE_WIN, RST_FE_WIN);
        pulse_ferr();
        check({27'h0, state, brake}, {27'h0, 3'h6, BRK_QUICK});
        finish_test();
    end
endmodule
